/* File: hw/usbe_pkg.sv */
/*
 Shared constants and types of the endpoint interface unit.
 Assumes one 8-bit register bus and a serial engine on the same clock.
*/
package usbe_pkg;
	localparam int NUM_EP = 4;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_PW = 3;
	// Slots: 0 hub control (or extra endpoint), 1..3 function ep0..2
	localparam logic [3:0][15:0] OFS_CFG = {16'h1fe3, 16'h1fe4, 16'h0044, 16'h1fe7};
	localparam logic [3:0][15:0] OFS_DATA = {16'h1fd3, 16'h1fd4, 16'h1fd5, 16'h1fd7};
	localparam logic [3:0][15:0] OFS_CMD = {16'h1fdb, 16'h1fdc, 16'h1fdd, 16'h1fa7};
	localparam logic [3:0][15:0] OFS_CSR = {16'h1fa2, 16'h1fa3, 16'h1fa4, 16'h1fa5};
	localparam logic [15:0] OFS_HADDR = 16'h1fef;
	localparam logic [15:0] OFS_FUNCTION_BUS_ADDRESS = 16'h1fee;
	localparam logic [15:0] OFS_GSTATE = 16'h1ff5;
	localparam logic [15:0] OFS_ISR = 16'h1ff7;
	localparam logic [15:0] OFS_ICR = 16'h1ff6;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int CFG_ON = 7;
	localparam int CFG_TOG = 3;
	localparam int CFG_INSEL = 2;
	localparam int CFG_CAT_HI = 1;
	localparam int CFG_CAT_LO = 0;
	localparam int CSR_STSENT = 3;
	localparam int CSR_SETUP = 2;
	localparam int CSR_OUTRX = 1;
	localparam int CSR_DONE = 0;
	localparam int CMD_DIR = 7;
	localparam int CMD_FIN = 6;
	localparam int CMD_STALL = 5;
	localparam int CMD_LOADED = 4;
	localparam int ADR_MODE = 7;
	localparam int GST_COMMIT = 0;
	localparam logic [1:0] CAT_CTRL = 2'h0;
	localparam logic [1:0] TOK_SETUP = 2'h0;
	localparam logic [1:0] TOK_OUT = 2'h1;
	localparam logic [1:0] TOK_IN = 2'h2;
	localparam logic [1:0] HS_ACK = 2'h0;
	localparam logic [1:0] HS_NAK = 2'h1;
	localparam logic [1:0] HS_STALL = 2'h2;
	typedef enum logic [3:0] {RK_NONE, RK_CFG, RK_CSR, RK_CMD, RK_DATA, RK_HADDR,
		RK_FUNCTION_BUS_ADDRESS, RK_GSTATE, RK_ISR, RK_ICR} usbe_rk_t;
	typedef enum logic [1:0] {RSP_ACK, RSP_NAK, RSP_STALL} usbe_rsp_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_WAIT} usbe_st_t;
	typedef struct packed {
		usbe_rk_t kind;
		logic [1:0] slot;
	} usbe_dec_t;

	function automatic usbe_dec_t usbe_decode(input logic [15:0] a);
		usbe_dec_t d;
		d.kind = RK_NONE;
		d.slot = 2'h0;
		for (int i = 0; i < NUM_EP; i++) begin
			if (a == OFS_CFG[i]) begin
				d.kind = RK_CFG;
				d.slot = 2'(i);
			end
			if (a == OFS_DATA[i]) begin
				d.kind = RK_DATA;
				d.slot = 2'(i);
			end
			if (a == OFS_CMD[i]) begin
				d.kind = RK_CMD;
				d.slot = 2'(i);
			end
			if (a == OFS_CSR[i]) begin
				d.kind = RK_CSR;
				d.slot = 2'(i);
			end
		end
		if (a == OFS_HADDR) d.kind = RK_HADDR;
		if (a == OFS_FUNCTION_BUS_ADDRESS) d.kind = RK_FUNCTION_BUS_ADDRESS;
		if (a == OFS_GSTATE) d.kind = RK_GSTATE;
		if (a == OFS_ISR) d.kind = RK_ISR;
		if (a == OFS_ICR) d.kind = RK_ICR;
		return d;
	endfunction
endpackage

/* File: hw/usbe_fifo.sv */
/*
 Endpoint packet buffer with pop, push, flush and a non-destructive peek.
 Assumes DEPTH is a power of two.
*/
`timescale 1ns/1ps
module usbe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int PW = $clog2(DEPTH)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	input wire logic wr_en_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic rd_en_i,
	output logic [WIDTH-1:0] rd_data_o,
	input wire logic [PW-1:0] peek_idx_i,
	output logic [WIDTH-1:0] peek_data_o,
	output logic [PW:0] count_o
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} usbe_fifo_t;
	usbe_fifo_t s_reg, s_next;
	logic wr_ok;
	logic rd_ok;

	// Writes into a full buffer are dropped; the packet is longer than allowed
	assign wr_ok = wr_en_i && (s_reg.cnt != (PW+1)'(DEPTH));
	assign rd_ok = rd_en_i && (s_reg.cnt != '0);
	assign rd_data_o = s_reg.mem[s_reg.rp];
	assign peek_data_o = s_reg.mem[PW'(s_reg.rp + peek_idx_i)];
	assign count_o = s_reg.cnt;

	always_comb begin
		s_next = s_reg;
		if (flush_i) begin
			s_next.wp = '0;
			s_next.rp = '0;
			s_next.cnt = '0;
		end else begin
			if (wr_ok) begin
				s_next.mem[s_reg.wp] = wr_data_i;
				s_next.wp = PW'(s_reg.wp + 1'b1);
			end
			if (rd_ok) s_next.rp = PW'(s_reg.rp + 1'b1);
			s_next.cnt = (PW+1)'(s_reg.cnt + (PW+1)'(wr_ok) - (PW+1)'(rd_ok));
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) s_reg <= '0;
		else s_reg <= s_next;
	end
endmodule

/* File: hw/usbe_ep_select.sv */
/*
 Maps a token's address and endpoint number onto an endpoint slot.
 Assumes active ids are already committed copies of the address registers.
*/
`timescale 1ns/1ps
module usbe_ep_select
	import usbe_pkg::*;
(
	input wire logic [6:0] tok_addr_i,
	input wire logic [3:0] tok_ep_i,
	input wire logic [6:0] hub_id_i,
	input wire logic [6:0] func_id_i,
	input wire logic merged_i,
	input wire logic func_on_i,
	output logic hit_o,
	output logic [1:0] slot_o
);
	always_comb begin
		hit_o = 1'b0;
		slot_o = 2'h0;
		if (merged_i) begin
			// All four endpoints on one address, hub slot as ep3
			hit_o = (tok_addr_i == func_id_i) && (tok_ep_i < 4'h4);
			slot_o = 2'(tok_ep_i + 4'h1);
		end else if (tok_addr_i == hub_id_i && tok_ep_i == 4'h0) begin
			hit_o = 1'b1;
		end else if (func_on_i && tok_addr_i == func_id_i && tok_ep_i < 4'h3) begin
			hit_o = 1'b1;
			slot_o = 2'(tok_ep_i + 4'h1);
		end
	end
endmodule

/* File: hw/usbe_endpoint_interface_unit.sv */
/*
 Endpoint interface unit: control and interrupt/bulk transaction responses
 and the firmware register file. Assumes a serial engine on SYS_CLK_I that
 delivers decoded tokens, received bytes and host handshakes.
*/
`timescale 1ns/1ps
module usbe_endpoint_interface_unit
	import usbe_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic [15:0] BUS_ADDR_I,
	input wire logic [7:0] BUS_WDATA_I,
	input wire logic BUS_WR_I,
	input wire logic BUS_RD_I,
	output logic [7:0] BUS_RDATA_O,
	input wire logic TOK_VALID_I,
	input wire logic [1:0] TOK_KIND_I,
	input wire logic [6:0] TOK_ADDR_I,
	input wire logic [3:0] TOK_EP_I,
	input wire logic RX_VALID_I,
	input wire logic [7:0] RX_DATA_I,
	input wire logic RX_END_I,
	input wire logic RX_OK_I,
	input wire logic RX_PID1_I,
	output logic HS_VALID_O,
	output logic [1:0] HS_CODE_O,
	output logic TX_VALID_O,
	output logic [7:0] TX_DATA_O,
	output logic TX_ZLEN_O,
	output logic TX_LAST_O,
	output logic TX_PID1_O,
	input wire logic TX_READY_I,
	input wire logic HOST_ACK_I,
	input wire logic HOST_TIMEOUT_I,
	output logic USB_INT_O
);
	typedef struct packed {
		usbe_st_t st;
		usbe_rsp_t rsp;
		logic [1:0] slot;
		logic [1:0] kind;
		logic [FIFO_PW-1:0] txi;
		logic zlen;
		logic pid1;
		logic fromfifo;
		logic [NUM_EP-1:0] on, insel, tog;
		logic [NUM_EP-1:0][1:0] cat;
		logic [NUM_EP-1:0] done, outrx, setup, stsent;
		logic [NUM_EP-1:0] dir, fin, stall, loaded;
		logic [NUM_EP-1:0] isr;
		logic [7:0] haddr, function_bus_address;
		logic [6:0] hact, fact;
		logic [7:0] rdata;
		logic hs_v;
		logic [1:0] hs_code;
	} usbe_state_t;
	usbe_state_t s_reg, s_next;

	usbe_dec_t dec;
	logic sel_hit, sel_ctrl, cur_ctrl, tok_take, tx_last, rx_wr, bus_commit, tog_sel;
	logic [1:0] sel_slot;
	logic [6:0] haddr_id;
	logic [NUM_EP-1:0] flush, fifo_wr, fifo_pop;
	logic [NUM_EP-1:0][7:0] fifo_rd, fifo_peek;
	logic [NUM_EP-1:0][FIFO_PW:0] fifo_cnt;

	// ------------------------------------------------------------
	// Decode and endpoint buffers
	// ------------------------------------------------------------
	assign dec = usbe_decode(BUS_ADDR_I);
	assign sel_ctrl = s_reg.cat[sel_slot] == CAT_CTRL;
	assign cur_ctrl = s_reg.cat[s_reg.slot] == CAT_CTRL;
	assign tok_take = s_reg.st == ST_IDLE && TOK_VALID_I && sel_hit;
	assign bus_commit = BUS_WR_I && dec.kind == RK_GSTATE && BUS_WDATA_I[GST_COMMIT];
	assign haddr_id = s_reg.haddr[6:0];
	assign tog_sel = s_reg.tog[s_reg.slot];
	assign tx_last = s_reg.zlen || ((FIFO_PW+1)'(s_reg.txi) + 1'b1 == fifo_cnt[s_reg.slot]);

	usbe_ep_select u_sel (
		.tok_addr_i(TOK_ADDR_I),
		.tok_ep_i(TOK_EP_I),
		.hub_id_i(s_reg.hact),
		.func_id_i(s_reg.fact),
		.merged_i(s_reg.haddr[ADR_MODE]),
		.func_on_i(s_reg.function_bus_address[ADR_MODE]),
		.hit_o(sel_hit),
		.slot_o(sel_slot)
	);

	// Bus pushes lose to received bytes; firmware must not fill a busy endpoint
	for (genvar e = 0; e < NUM_EP; e++) begin : g_fifo
		assign fifo_wr[e] = (rx_wr && s_reg.slot == 2'(e)) ||
			(!rx_wr && BUS_WR_I && dec.kind == RK_DATA && dec.slot == 2'(e));
		assign fifo_pop[e] = BUS_RD_I && dec.kind == RK_DATA && dec.slot == 2'(e);
		usbe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .PW(FIFO_PW)) u_fifo (
			.clk_i(SYS_CLK_I),
			.rst_n_i(RST_N_I),
			.flush_i(flush[e]),
			.wr_en_i(fifo_wr[e]),
			.wr_data_i(rx_wr ? RX_DATA_I : BUS_WDATA_I),
			.rd_en_i(fifo_pop[e]),
			.rd_data_o(fifo_rd[e]),
			.peek_idx_i(s_reg.txi),
			.peek_data_o(fifo_peek[e]),
			.count_o(fifo_cnt[e])
		);
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.hs_v = 1'b0;
		s_next.rdata = RST_BYTE;
		flush = '0;
		rx_wr = 1'b0;
		if (BUS_RD_I) begin
			unique case (dec.kind)
				RK_CFG: begin
					s_next.rdata[CFG_ON] = s_reg.on[dec.slot];
					s_next.rdata[CFG_TOG] = s_reg.tog[dec.slot];
					s_next.rdata[CFG_INSEL] = s_reg.insel[dec.slot];
					s_next.rdata[CFG_CAT_HI:CFG_CAT_LO] = s_reg.cat[dec.slot];
				end
				RK_CSR: begin
					s_next.rdata[CSR_STSENT] = s_reg.stsent[dec.slot];
					s_next.rdata[CSR_SETUP] = s_reg.setup[dec.slot];
					s_next.rdata[CSR_OUTRX] = s_reg.outrx[dec.slot];
					s_next.rdata[CSR_DONE] = s_reg.done[dec.slot];
				end
				RK_CMD: begin
					s_next.rdata[CMD_DIR] = s_reg.dir[dec.slot];
					s_next.rdata[CMD_FIN] = s_reg.fin[dec.slot];
					s_next.rdata[CMD_STALL] = s_reg.stall[dec.slot];
					s_next.rdata[CMD_LOADED] = s_reg.loaded[dec.slot];
				end
				RK_DATA: s_next.rdata = fifo_rd[dec.slot];
				RK_HADDR: s_next.rdata = s_reg.haddr;
				RK_FUNCTION_BUS_ADDRESS: s_next.rdata = s_reg.function_bus_address;
				RK_ISR: s_next.rdata[NUM_EP-1:0] = s_reg.isr;
				default: s_next.rdata = RST_BYTE;
			endcase
		end
		if (BUS_WR_I) begin
			unique case (dec.kind)
				RK_CFG: begin
					s_next.on[dec.slot] = BUS_WDATA_I[CFG_ON];
					s_next.tog[dec.slot] = BUS_WDATA_I[CFG_TOG];
					s_next.insel[dec.slot] = BUS_WDATA_I[CFG_INSEL];
					s_next.cat[dec.slot] = BUS_WDATA_I[CFG_CAT_HI:CFG_CAT_LO];
				end
				RK_CMD: begin
					s_next.dir[dec.slot] = BUS_WDATA_I[CMD_DIR];
					s_next.fin[dec.slot] = BUS_WDATA_I[CMD_FIN];
					s_next.stall[dec.slot] = BUS_WDATA_I[CMD_STALL];
					s_next.loaded[dec.slot] = BUS_WDATA_I[CMD_LOADED];
					// Acknowledge bits clear status flags and read back as zero
					if (BUS_WDATA_I[CSR_STSENT]) s_next.stsent[dec.slot] = 1'b0;
					if (BUS_WDATA_I[CSR_SETUP]) s_next.setup[dec.slot] = 1'b0;
					if (BUS_WDATA_I[CSR_OUTRX]) s_next.outrx[dec.slot] = 1'b0;
					if (BUS_WDATA_I[CSR_DONE]) s_next.done[dec.slot] = 1'b0;
				end
				RK_HADDR: s_next.haddr = BUS_WDATA_I;
				RK_FUNCTION_BUS_ADDRESS: s_next.function_bus_address = BUS_WDATA_I;
				RK_GSTATE: begin
					if (bus_commit) begin
						s_next.hact = s_reg.haddr[6:0];
						s_next.fact = s_reg.function_bus_address[6:0];
					end
				end
				RK_ICR: s_next.isr = s_reg.isr & ~BUS_WDATA_I[NUM_EP-1:0];
				default: s_next.hact = s_next.hact;
			endcase
		end
		// Hardware events come last so they beat a same-cycle register write, whether that write sets or clears
		unique case (s_reg.st)
			ST_IDLE: begin
				if (tok_take && s_reg.on[sel_slot]) begin
					s_next.slot = sel_slot;
					s_next.kind = TOK_KIND_I;
					s_next.txi = '0;
					if (TOK_KIND_I == TOK_IN) begin
						if (sel_ctrl && !s_reg.dir[sel_slot]) begin
							s_next.st = ST_TX;
							s_next.zlen = 1'b1;
							s_next.pid1 = 1'b1;
							s_next.fromfifo = 1'b0;
						end else if (sel_ctrl || s_reg.insel[sel_slot]) begin
							if (s_reg.stall[sel_slot]) begin
								s_next.hs_v = 1'b1;
								s_next.hs_code = HS_STALL;
								s_next.stsent[sel_slot] = 1'b1;
							end else if (s_reg.loaded[sel_slot]) begin
								s_next.st = ST_TX;
								s_next.zlen = fifo_cnt[sel_slot] == '0;
								s_next.pid1 = s_reg.tog[sel_slot];
								s_next.fromfifo = 1'b1;
							end else begin
								s_next.hs_v = 1'b1;
								s_next.hs_code = HS_NAK;
							end
						end
					end else if (TOK_KIND_I == TOK_SETUP) begin
						if (sel_ctrl) begin
							s_next.st = ST_RX;
							s_next.rsp = RSP_ACK;
							flush[sel_slot] = 1'b1;
						end
					end else if (sel_ctrl || !s_reg.insel[sel_slot]) begin
						s_next.st = ST_RX;
						if (sel_ctrl && s_reg.dir[sel_slot]) begin
							s_next.rsp = s_reg.done[sel_slot] ? RSP_NAK : RSP_ACK;
						end else if (s_reg.stall[sel_slot]) begin
							s_next.rsp = RSP_STALL;
						end else if (s_reg.outrx[sel_slot]) begin
							s_next.rsp = RSP_NAK;
						end else begin
							s_next.rsp = RSP_ACK;
						end
					end
				end
			end
			ST_RX: begin
				rx_wr = RX_VALID_I && s_reg.rsp == RSP_ACK;
				if (RX_END_I) begin
					s_next.st = ST_IDLE;
					if (!RX_OK_I) begin
						// Corrupt packet: no handshake, host will retry
						if (s_reg.rsp == RSP_ACK) flush[s_reg.slot] = 1'b1;
					end else begin
						s_next.hs_v = 1'b1;
						unique case (s_reg.rsp)
							RSP_STALL: begin
								s_next.hs_code = HS_STALL;
								s_next.stsent[s_reg.slot] = 1'b1;
							end
							RSP_NAK: s_next.hs_code = HS_NAK;
							RSP_ACK: begin
								s_next.hs_code = HS_ACK;
								if (s_reg.kind == TOK_SETUP) begin
									s_next.setup[s_reg.slot] = 1'b1;
									s_next.done[s_reg.slot] = 1'b0;
									s_next.outrx[s_reg.slot] = 1'b0;
									s_next.stsent[s_reg.slot] = 1'b0;
									s_next.fin[s_reg.slot] = 1'b0;
									s_next.stall[s_reg.slot] = 1'b0;
									s_next.loaded[s_reg.slot] = 1'b0;
									s_next.tog[s_reg.slot] = 1'b1;
									s_next.isr[s_reg.slot] = 1'b1;
								end else if (cur_ctrl && s_reg.dir[s_reg.slot]) begin
									s_next.outrx[s_reg.slot] = 1'b1;
									s_next.isr[s_reg.slot] = 1'b1;
								end else if (RX_PID1_I == s_reg.tog[s_reg.slot]) begin
									s_next.outrx[s_reg.slot] = 1'b1;
									s_next.tog[s_reg.slot] = ~s_reg.tog[s_reg.slot];
									s_next.isr[s_reg.slot] = 1'b1;
								end else begin
									flush[s_reg.slot] = 1'b1;
								end
							end
							default: s_next.hs_code = HS_NAK;
						endcase
					end
				end
			end
			ST_TX: begin
				if (TX_READY_I) begin
					if (tx_last) s_next.st = ST_WAIT;
					else s_next.txi = FIFO_PW'(s_reg.txi + 1'b1);
				end
			end
			ST_WAIT: begin
				if (HOST_ACK_I) begin
					s_next.st = ST_IDLE;
					s_next.done[s_reg.slot] = 1'b1;
					s_next.isr[s_reg.slot] = 1'b1;
					if (s_reg.fromfifo) begin
						s_next.loaded[s_reg.slot] = 1'b0;
						s_next.tog[s_reg.slot] = ~s_reg.tog[s_reg.slot];
						flush[s_reg.slot] = 1'b1;
					end
				end else if (HOST_TIMEOUT_I) begin
					s_next.st = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) s_reg <= '0;
		else s_reg <= s_next;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign BUS_RDATA_O = s_reg.rdata;
	assign HS_VALID_O = s_reg.hs_v;
	assign HS_CODE_O = s_reg.hs_code;
	assign TX_VALID_O = s_reg.st == ST_TX;
	assign TX_DATA_O = s_reg.zlen ? RST_BYTE : fifo_peek[s_reg.slot];
	assign TX_ZLEN_O = s_reg.zlen;
	assign TX_LAST_O = TX_VALID_O && tx_last;
	assign TX_PID1_O = s_reg.pid1;
	assign USB_INT_O = |s_reg.isr;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking dc @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence in_take_s;
		tok_take && s_reg.on[sel_slot] && TOK_KIND_I == TOK_IN;
	endsequence
	sequence setup_end_s;
		s_reg.st == ST_RX && s_reg.kind == TOK_SETUP && s_reg.rsp == RSP_ACK && RX_END_I && RX_OK_I;
	endsequence

	zlp_status_a: assert property (in_take_s ##0 (sel_ctrl && !s_reg.dir[sel_slot])
		|=> TX_VALID_O && TX_ZLEN_O && TX_PID1_O && TX_LAST_O) else $error("status IN not a DATA1 zero packet");
	nak_unloaded_a: assert property (in_take_s ##0 (sel_ctrl && s_reg.dir[sel_slot] &&
		!s_reg.stall[sel_slot] && !s_reg.loaded[sel_slot]) |=> HS_VALID_O && HS_CODE_O == HS_NAK)
		else $error("unloaded IN not NAKed");
	in_complete_a: assert property (s_reg.st == ST_WAIT && HOST_ACK_I && s_reg.fromfifo
		|=> !s_reg.loaded[s_reg.slot] && s_reg.done[s_reg.slot] && USB_INT_O && tog_sel != $past(tog_sel))
		else $error("IN completion flags wrong");
	status_nak_a: assert property (tok_take && s_reg.on[sel_slot] && TOK_KIND_I == TOK_OUT &&
		sel_ctrl && s_reg.dir[sel_slot] && s_reg.done[sel_slot] |=> s_reg.st == ST_RX && s_reg.rsp == RSP_NAK)
		else $error("status OUT not NAKed while done");
	setup_clear_a: assert property (setup_end_s |=> s_reg.setup[s_reg.slot] && !s_reg.fin[s_reg.slot]
		&& HS_VALID_O && HS_CODE_O == HS_ACK) else $error("SETUP did not clear final flag");
	addr_commit_a: assert property (bus_commit |=> s_reg.hact == $past(haddr_id))
		else $error("hub id not committed");
	addr_hold_a: assert property (!bus_commit |=> $stable(s_reg.hact))
		else $error("hub id changed without commit");
	cfg_reserved_a: assert property (BUS_RD_I && dec.kind == RK_CFG |=> BUS_RDATA_O[6:4] == 3'h0)
		else $error("reserved config bits not zero");
	disabled_quiet_a: assert property (tok_take && !s_reg.on[sel_slot]
		|=> !HS_VALID_O && s_reg.st == ST_IDLE) else $error("disabled endpoint answered");
endmodule

/* File: tb/usbe_host_model.sv */
/*
 Upstream host and serial engine stand-in: tokens, data packets, handshakes.
 Assumes the caller calls its tasks on SYS_CLK_I rising edges.
*/
`timescale 1ns/1ps
module usbe_host_model (
	input wire logic clk_i,
	input wire logic tx_valid_i,
	input wire logic tx_last_i,
	output logic tok_valid_o,
	output logic [1:0] tok_kind_o,
	output logic [6:0] tok_addr_o,
	output logic [3:0] tok_ep_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_end_o,
	output logic rx_ok_o,
	output logic rx_pid1_o,
	output logic tx_ready_o,
	output logic host_ack_o,
	output logic host_timeout_o
);
	initial begin
		{tok_valid_o, tok_kind_o, tok_addr_o, tok_ep_o, rx_valid_o, rx_data_o} = '0;
		{rx_end_o, rx_ok_o, rx_pid1_o, tx_ready_o, host_ack_o, host_timeout_o} = '0;
	end
	task automatic tok(input logic [1:0] k, input logic [6:0] a, input logic [3:0] e);
		@(posedge clk_i);
		tok_valid_o <= 1'b1;
		tok_kind_o <= k;
		tok_addr_o <= a;
		tok_ep_o <= e;
		@(posedge clk_i);
		tok_valid_o <= 1'b0;
		// Released fields go to junk so a stale address is never trusted
		tok_addr_o <= ~a;
		tok_ep_o <= ~e;
	endtask
	task automatic dat(input logic [7:0] b[$], input logic p1);
		foreach (b[i]) begin
			rx_valid_o <= 1'b1;
			rx_data_o <= b[i];
			@(posedge clk_i);
		end
		rx_valid_o <= 1'b0;
		rx_data_o <= ~rx_data_o;
		rx_end_o <= 1'b1;
		rx_ok_o <= 1'b1;
		rx_pid1_o <= p1;
		@(posedge clk_i);
		rx_end_o <= 1'b0;
		rx_ok_o <= 1'b0;
		rx_pid1_o <= ~p1;
	endtask
	// A timeout instead of an ACK makes the device retry on the next IN
	task automatic take(input logic ack);
		tx_ready_o <= 1'b1;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (tx_valid_i && tx_last_i) break;
		end
		tx_ready_o <= 1'b0;
		host_ack_o <= ack;
		host_timeout_o <= !ack;
		@(posedge clk_i);
		host_ack_o <= 1'b0;
		host_timeout_o <= 1'b0;
	endtask
endmodule

/* File: tb/usbe_endpoint_interface_unit_test.sv */
/*
 Self-checking bench: register file, control transfers, bulk OUT.
 Assumes the host model drives the serial side.
*/
`timescale 1ns/1ps
module usbe_endpoint_interface_unit_test
	import usbe_pkg::*;
;
	logic SYS_CLK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic [15:0] BUS_ADDR_I = 16'h0000;
	logic [7:0] BUS_WDATA_I = 8'h00;
	logic BUS_WR_I = 1'b0;
	logic BUS_RD_I = 1'b0;
	logic [7:0] BUS_RDATA_O, RX_DATA_I, TX_DATA_O;
	logic TOK_VALID_I, RX_VALID_I, RX_END_I, RX_OK_I, RX_PID1_I, TX_READY_I, HOST_ACK_I, HOST_TIMEOUT_I;
	logic [1:0] TOK_KIND_I, HS_CODE_O;
	logic [6:0] TOK_ADDR_I;
	logic [3:0] TOK_EP_I;
	logic HS_VALID_O, TX_VALID_O, TX_ZLEN_O, TX_LAST_O, TX_PID1_O, USB_INT_O;
	logic rd_q = 1'b0;
	logic [11:0] exp_q[$];
	logic [7:0] bq[$];
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	usbe_endpoint_interface_unit uut (.SYS_CLK_I, .RST_N_I, .BUS_ADDR_I, .BUS_WDATA_I, .BUS_WR_I, .BUS_RD_I,
		.BUS_RDATA_O, .TOK_VALID_I, .TOK_KIND_I, .TOK_ADDR_I, .TOK_EP_I, .RX_VALID_I, .RX_DATA_I, .RX_END_I,
		.RX_OK_I, .RX_PID1_I, .HS_VALID_O, .HS_CODE_O, .TX_VALID_O, .TX_DATA_O, .TX_ZLEN_O, .TX_LAST_O,
		.TX_PID1_O, .TX_READY_I, .HOST_ACK_I, .HOST_TIMEOUT_I, .USB_INT_O);
	usbe_host_model host (.clk_i(SYS_CLK_I), .tx_valid_i(TX_VALID_O), .tx_last_i(TX_LAST_O),
		.tok_valid_o(TOK_VALID_I), .tok_kind_o(TOK_KIND_I), .tok_addr_o(TOK_ADDR_I), .tok_ep_o(TOK_EP_I),
		.rx_valid_o(RX_VALID_I), .rx_data_o(RX_DATA_I), .rx_end_o(RX_END_I), .rx_ok_o(RX_OK_I),
		.rx_pid1_o(RX_PID1_I), .tx_ready_o(TX_READY_I), .host_ack_o(HOST_ACK_I), .host_timeout_o(HOST_TIMEOUT_I));
	// ----------------
	// Checking
	// ----------------
	always #2 SYS_CLK_I = ~SYS_CLK_I;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string w, input logic [11:0] s, input logic [11:0] e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", w, e, s);
		end
	endtask
	// Unexpected events compare against an impossible note
	task automatic seen(input string w, input logic [11:0] s);
		if (exp_q.size() == 0) check(w, s, 12'hfff);
		else check(w, s, exp_q.pop_front());
	endtask
	always @(posedge SYS_CLK_I) begin
		rd_q <= BUS_RD_I;
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			finish_test();
		end
	end
	always @(negedge SYS_CLK_I) begin
		if (rd_q) seen("read data", {4'h0, BUS_RDATA_O});
		if (HS_VALID_O) seen("handshake", {4'h1, 6'h00, HS_CODE_O});
		if (TX_VALID_O && TX_READY_I) seen("tx beat", {2'h2, TX_PID1_O, TX_ZLEN_O, TX_DATA_O});
	end
	// ----------------
	// Stimulus
	// ----------------
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge SYS_CLK_I);
		BUS_ADDR_I <= a;
		BUS_WDATA_I <= d;
		BUS_WR_I <= 1'b1;
		@(posedge SYS_CLK_I);
		BUS_WR_I <= 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back({4'h0, e});
		@(posedge SYS_CLK_I);
		BUS_ADDR_I <= a;
		BUS_RD_I <= 1'b1;
		@(posedge SYS_CLK_I);
		BUS_RD_I <= 1'b0;
	endtask
	task automatic drain;
		for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(posedge SYS_CLK_I);
		repeat (3) @(posedge SYS_CLK_I);
		check("pending notes", 12'(exp_q.size()), 12'h000);
		exp_q = {};
	endtask
	task automatic chk_int(input logic v);
		@(negedge SYS_CLK_I);
		check("interrupt", {11'h000, USB_INT_O}, {11'h000, v});
	endtask
	task automatic in_zlp(input logic [6:0] a, input logic ack);
		host.tok(TOK_IN, a, 4'h0);
		exp_q.push_back({2'h2, 1'b1, 1'b1, 8'h00});
		host.take(ack);
		drain();
	endtask
	task automatic setup_xfer;
		wr_reg(OFS_CMD[1], 8'h40);
		bq = {};
		repeat (8) bq.push_back(8'($urandom));
		host.tok(TOK_SETUP, 7'h00, 4'h0);
		exp_q.push_back({4'h1, 6'h00, HS_ACK});
		host.dat(bq, 1'b0);
		drain();
		chk_int(1'b1);
		rd_reg(OFS_CSR[1], 8'h04);
		rd_reg(OFS_CMD[1], 8'h00);
		rd_reg(OFS_CFG[1], 8'h88);
		foreach (bq[i]) rd_reg(OFS_DATA[1], bq[i]);
		drain();
		$display("test setup done");
	endtask
	initial begin
		logic [7:0] r;
		void'($urandom(32'h4e60220c));
		repeat (2) @(posedge SYS_CLK_I);
		RST_N_I <= 1'b1;
		for (int i = 0; i < NUM_EP; i++) rd_reg(OFS_CFG[i], 8'h00);
		rd_reg(OFS_HADDR, 8'h00);
		rd_reg(16'h1000, 8'h00);
		r = 8'($urandom);
		wr_reg(OFS_CFG[2], r);
		rd_reg(OFS_CFG[2], r & 8'h8f);
		wr_reg(OFS_CFG[2], 8'h00);
		// Hub id kept off 0 and 5 so it never shadows the function endpoints
		wr_reg(OFS_HADDR, {3'h3, r[4:0]});
		rd_reg(OFS_HADDR, {3'h3, r[4:0]});
		wr_reg(OFS_CSR[1], 8'hff);
		wr_reg(OFS_FUNCTION_BUS_ADDRESS, 8'h80);
		wr_reg(OFS_GSTATE, 8'h01);
		host.tok(TOK_IN, 7'h00, 4'h0);
		rd_reg(OFS_CSR[1], 8'h00);
		drain();
		$display("test registers done");
		wr_reg(OFS_CFG[1], 8'h80);
		setup_xfer();
		wr_reg(OFS_CMD[1], 8'h84);
		wr_reg(OFS_ICR, 8'h02);
		chk_int(1'b0);
		host.tok(TOK_IN, 7'h00, 4'h0);
		exp_q.push_back({4'h1, 6'h00, HS_NAK});
		drain();
		bq = {8'($urandom), 8'($urandom)};
		foreach (bq[i]) wr_reg(OFS_DATA[1], bq[i]);
		wr_reg(OFS_CMD[1], 8'h90);
		for (int k = 0; k < 2; k++) begin
			host.tok(TOK_IN, 7'h00, 4'h0);
			foreach (bq[i]) exp_q.push_back({2'h2, 1'b1, 1'b0, bq[i]});
			host.take(k[0]);
			drain();
		end
		rd_reg(OFS_CSR[1], 8'h01);
		rd_reg(OFS_CMD[1], 8'h80);
		rd_reg(OFS_CFG[1], 8'h80);
		bq = {};
		for (int k = 0; k < 2; k++) begin
			host.tok(TOK_OUT, 7'h00, 4'h0);
			exp_q.push_back({4'h1, 6'h00, k ? HS_ACK : HS_NAK});
			host.dat(bq, 1'b1);
			drain();
			wr_reg(OFS_CMD[1], 8'he1);
		end
		rd_reg(OFS_CSR[1], 8'h02);
		$display("test control read done");
		setup_xfer();
		wr_reg(OFS_CMD[1], 8'h64);
		for (int k = 0; k < 2; k++) in_zlp(7'h00, k[0]);
		rd_reg(OFS_CSR[1], 8'h01);
		wr_reg(OFS_FUNCTION_BUS_ADDRESS, 8'h85);
		host.tok(TOK_IN, 7'h05, 4'h0);
		drain();
		wr_reg(OFS_GSTATE, 8'h01);
		rd_reg(OFS_GSTATE, 8'h00);
		in_zlp(7'h05, 1'b1);
		host.tok(TOK_IN, 7'h00, 4'h0);
		drain();
		$display("test address done");
		wr_reg(OFS_CFG[2], 8'h82);
		bq = {8'($urandom), 8'($urandom), 8'($urandom)};
		host.tok(TOK_OUT, 7'h05, 4'h1);
		exp_q.push_back({4'h1, 6'h00, HS_ACK});
		host.dat(bq, 1'b0);
		drain();
		rd_reg(OFS_CSR[2], 8'h02);
		foreach (bq[i]) rd_reg(OFS_DATA[2], bq[i]);
		rd_reg(OFS_CFG[2], 8'h8a);
		drain();
		$display("test bulk out done");
		wr_reg(OFS_CFG[3], 8'h87);
		bq = {8'($urandom), 8'($urandom)};
		foreach (bq[i]) wr_reg(OFS_DATA[3], bq[i]);
		wr_reg(OFS_CMD[3], 8'h10);
		host.tok(TOK_IN, 7'h05, 4'h2);
		foreach (bq[i]) exp_q.push_back({2'h2, 1'b0, 1'b0, bq[i]});
		host.take(1'b1);
		drain();
		rd_reg(OFS_CSR[3], 8'h01);
		rd_reg(OFS_CFG[3], 8'h8f);
		wr_reg(OFS_FUNCTION_BUS_ADDRESS, 8'h05);
		wr_reg(OFS_HADDR, 8'h80);
		wr_reg(OFS_CFG[0], 8'h87);
		for (int k = 2; k < 4; k++) begin
			host.tok(TOK_IN, 7'h05, 4'(k));
			exp_q.push_back({4'h1, 6'h00, HS_NAK});
			drain();
		end
		$display("test in and merged done");
		finish_test();
	end
endmodule
